// >>> hw/eip_top.sv
// Contract
// - Five source kinds, levels zero to sixteen; the code has two kinds, NMI and pins.
// - Level zero source is never presented.
// - NMI level sixteen, accepted regardless of mask.
// - NMI edge only, polarity bit selects.
// - NMI acceptance loads mask level fifteen.
// - Each pin selects low, falling or rising.
// - Each pin has priority zero to fifteen.
// - Low level request follows the pin.
// - Level mode flag reads current request level.
// - Falling edge on pin raises request.
// - Edge request stays latched until accepted.
// - Write zero clears only after reading one.
// - Pin acceptance loads mask with its priority.
//
// The implementer's own choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "eip_defines.svh"

module eip_top #(
	parameter int NPIN = 8
) (
	input  wire logic                clk_i,
	input  wire logic                rst_i,
	input  wire logic                wb_cyc_i,
	input  wire logic                wb_stb_i,
	input  wire logic                wb_we_i,
	input  wire logic [7:0]          wb_adr_i,
	input  wire logic [3:0]          wb_sel_i,
	input  wire logic [31:0]         wb_dat_i,
	output logic      [31:0]         wb_dat_o,
	output logic                     wb_ack_o,
	input  wire logic                nmi_pin_i,
	input  wire logic [NPIN-1:0]     ext_request_pin_i,
	input  wire logic [3:0]          cpu_mask_level_i,
	input  wire logic                cpu_accept_i,
	output logic                     req_o,
	output eip_pkg::eip_level_t      req_level_o,
	output logic                     req_nmi_o,
	output logic      [2:0]          req_pin_o,
	output logic                     mask_load_o,
	output logic      [3:0]          mask_value_o,
	output logic                     irq_o
);
	import eip_pkg::*;

	// Register state; all but arm_q and nmi_prev_q is software-visible.
	logic [NPIN:0]         ctl1_q;
	logic [2*NPIN-1:0]     ctl2_q;
	logic [15:0]           pra_q;
	logic [15:0]           prb_q;
	logic [`EIP_EVT_W-1:0] evt_sts_q;
	logic [`EIP_EVT_W-1:0] evt_en_q;
	logic [NPIN-1:0]       arm_q;
	logic                  nmi_prev_q;
	logic                  nmi_pend_q;

	// Per-pin wires.
	logic [NPIN-1:0]       pin_flag;
	logic [NPIN-1:0]       pin_evt;
	logic [NPIN-1:0]       acc_pin;
	logic [3:0]            prio [NPIN];

	// Arbitration result.
	logic                  found;
	eip_level_t            best_lvl;
	logic [2:0]            best_pin;
	eip_src_e              best_src;

	function automatic logic [31:0] merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [31:0] mask_v);
		merge = (old_v & ~mask_v) | (new_v & mask_v);
	endfunction

	// Bus decode. The slave answers one cycle after the request and releases
	// ack the cycle after, so back-to-back requests see a gap of one cycle.
	wire        bus_req  = wb_cyc_i & wb_stb_i;
	wire        rd_start = bus_req & ~wb_ack_o & ~wb_we_i;
	wire        wr_take  = bus_req & wb_ack_o & wb_we_i;
	wire [31:0] wmask    = {{8{wb_sel_i[3]}}, {8{wb_sel_i[2]}},
		{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};

	wire sel_ctl1 = (wb_adr_i == `EIP_OFS_CTL_ONE);
	wire sel_ctl2 = (wb_adr_i == `EIP_OFS_CTL_TWO);
	wire sel_pra  = (wb_adr_i == `EIP_OFS_PRIO_A);
	wire sel_prb  = (wb_adr_i == `EIP_OFS_PRIO_B);
	wire sel_rsts = (wb_adr_i == `EIP_OFS_REQ_STS);
	wire sel_ests = (wb_adr_i == `EIP_OFS_EVT_STS);
	wire sel_een  = (wb_adr_i == `EIP_OFS_EVT_EN);
	wire sel_eclr = (wb_adr_i == `EIP_OFS_EVT_CLR);

	wire wr_ctl1 = wr_take & sel_ctl1;
	wire wr_ctl2 = wr_take & sel_ctl2;
	wire wr_pra  = wr_take & sel_pra;
	wire wr_prb  = wr_take & sel_prb;
	wire wr_een  = wr_take & sel_een;
	wire wr_eclr = wr_take & sel_eclr;
	wire rd_sts  = rd_start & sel_rsts;
	wire wr_sts  = wr_take & sel_rsts & wb_sel_i[0];

	wire [NPIN-1:0] sense_edge = ctl1_q[NPIN-1:0];
	wire            nmi_rise   = ctl1_q[`EIP_NMI_POL_BIT];
	wire [NPIN:0]   req_sts    = {nmi_pend_q, pin_flag};
	wire [31:0]     prio_all   = {prb_q, pra_q};

	wire [31:0] rd_mux =
		sel_ctl1 ? 32'(ctl1_q) :
		sel_ctl2 ? 32'(ctl2_q) :
		sel_pra  ? 32'(pra_q) :
		sel_prb  ? 32'(prb_q) :
		sel_rsts ? 32'(req_sts) :
		sel_ests ? 32'(evt_sts_q) :
		sel_een  ? 32'(evt_en_q) :
		32'h0000_0000;

	// A software clear only takes effect on a flag that this master saw as one
	// in an earlier read; the arm drops as soon as the flag itself drops.
	wire [NPIN-1:0] sw_clr = {NPIN{wr_sts}} & ~wb_dat_i[NPIN-1:0] & arm_q;
	wire [NPIN-1:0] arm_d  = pin_flag & sense_edge & ~{NPIN{wr_sts}}
		& (arm_q | {NPIN{rd_sts}});

	// NMI is edge sensed only; the polarity bit picks rising or falling.
	wire nmi_hit = nmi_rise ? (nmi_pin_i & ~nmi_prev_q)
		: (~nmi_pin_i & nmi_prev_q);
	wire acc_any = cpu_accept_i & req_o;
	wire acc_nmi = acc_any & req_nmi_o;
	wire nmi_pend_d = nmi_hit | (nmi_pend_q & ~acc_nmi);

	wire [`EIP_EVT_W-1:0] evt   = {acc_any, nmi_hit, pin_evt};
	wire [`EIP_EVT_W-1:0] e_clr = {`EIP_EVT_W{wr_eclr}}
		& wb_dat_i[`EIP_EVT_W-1:0] & wmask[`EIP_EVT_W-1:0];
	// Hardware events win over a clear in the same cycle.
	wire [`EIP_EVT_W-1:0] evt_sts_d = evt | (evt_sts_q & ~e_clr);

	for (genvar g = 0; g < NPIN; g++)
	begin : g_pin
		eip_pin_detect u_det (
			.clk_i      (clk_i),
			.rst_i      (rst_i),
			.pin_i      (ext_request_pin_i[g]),
			.sense_i    (sense_edge[g]),
			.edge_sel_i (ctl2_q[2*g +: 2]),
			.clr_i      (sw_clr[g]),
			.acc_i      (acc_pin[g]),
			.flag_o     (pin_flag[g]),
			.evt_o      (pin_evt[g])
		);
		assign prio[g]    = prio_all[4*g +: 4];
		assign acc_pin[g] = acc_any & ~req_nmi_o & (req_pin_o == 3'(g));
	end

	// Highest level wins; among equal levels the lowest pin index wins.
	always_comb
	begin
		found    = 1'b0;
		best_lvl = '0;
		best_pin = '0;
		best_src = EIP_SRC_NONE;
		for (int i = 0; i < NPIN; i++)
		begin
			if (pin_flag[i] && prio[i] != `EIP_PRIO_OFF
				&& prio[i] > cpu_mask_level_i && {1'b0, prio[i]} > best_lvl)
			begin
				found    = 1'b1;
				best_lvl = {1'b0, prio[i]};
				best_pin = 3'(i);
				best_src = EIP_SRC_PIN;
			end
		end
		if (nmi_pend_q)
		begin
			found    = 1'b1;
			best_lvl = `EIP_NMI_LEVEL;
			best_pin = '0;
			best_src = EIP_SRC_NMI;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= 32'h0000_0000;
		end
		else
		begin
			wb_ack_o <= bus_req & ~wb_ack_o;
			if (rd_start)
				wb_dat_o <= rd_mux;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ctl1_q   <= `EIP_RST_CTL_ONE;
			ctl2_q   <= `EIP_RST_CTL_TWO;
			pra_q    <= `EIP_RST_PRIO;
			prb_q    <= `EIP_RST_PRIO;
			evt_en_q <= `EIP_RST_EVT;
		end
		else
		begin
			if (wr_ctl1)
				ctl1_q <= (NPIN+1)'(merge(32'(ctl1_q), wb_dat_i, wmask));
			if (wr_ctl2)
				ctl2_q <= (2*NPIN)'(merge(32'(ctl2_q), wb_dat_i, wmask));
			if (wr_pra)
				pra_q <= 16'(merge(32'(pra_q), wb_dat_i, wmask));
			if (wr_prb)
				prb_q <= 16'(merge(32'(prb_q), wb_dat_i, wmask));
			if (wr_een)
				evt_en_q <= `EIP_EVT_W'(merge(32'(evt_en_q), wb_dat_i, wmask));
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			arm_q      <= '0;
			nmi_prev_q <= `EIP_PIN_IDLE;
			nmi_pend_q <= 1'b0;
			evt_sts_q  <= `EIP_RST_EVT;
			irq_o      <= 1'b0;
		end
		else
		begin
			arm_q      <= arm_d;
			nmi_prev_q <= nmi_pin_i;
			nmi_pend_q <= nmi_pend_d;
			evt_sts_q  <= evt_sts_d;
			irq_o      <= |(evt_sts_q & evt_en_q);
		end
	end

	// The request is withdrawn for one cycle after an accept so that the core
	// never sees a stale source before the cleared flags are rearbitrated.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			req_o        <= 1'b0;
			req_level_o  <= '0;
			req_nmi_o    <= 1'b0;
			req_pin_o    <= '0;
			mask_load_o  <= 1'b0;
			mask_value_o <= 4'h0;
		end
		else
		begin
			req_o       <= found & ~acc_any;
			req_level_o <= best_lvl;
			req_nmi_o   <= (best_src == EIP_SRC_NMI);
			req_pin_o   <= best_pin;
			mask_load_o <= acc_any;
			if (acc_any)
				mask_value_o <= req_nmi_o ? `EIP_NMI_MASK : req_level_o[3:0];
		end
	end

	wire pin0_now = ext_request_pin_i[0];

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_LEVEL_RANGE: assert property (req_o |-> req_level_o <= `EIP_NMI_LEVEL)
		else $error("Presented level above sixteen.");
	AST_ZERO_MASKED: assert property (req_o |-> req_level_o != 5'h00)
		else $error("Masked source presented.");
	AST_NMI_FIXED: assert property (req_o && req_nmi_o |-> req_level_o == `EIP_NMI_LEVEL)
		else $error("NMI presented below sixteen.");
	AST_NMI_UNCOND: assert property (nmi_pend_q && !acc_any |=> req_o && req_nmi_o)
		else $error("Pending NMI not presented.");
	AST_NMI_EDGE: assert property (nmi_rise && $rose(nmi_pin_i) |=> nmi_pend_q)
		else $error("Selected NMI edge not latched.");
	AST_NMI_MASK: assert property (acc_nmi |=> mask_load_o && mask_value_o == `EIP_NMI_MASK)
		else $error("NMI accept did not load mask fifteen.");
	AST_PIN_MASK: assert property (acc_any && !req_nmi_o
		|=> mask_load_o && {1'b0, mask_value_o} == $past(req_level_o))
		else $error("Pin accept did not load its priority.");
	AST_LVL_READ: assert property (rd_sts && !sense_edge[0]
		|=> wb_ack_o && wb_dat_o[0] == !$past(pin0_now))
		else $error("Level flag read does not match pin.");
	AST_CLR_NEEDS_READ: assert property (wr_sts && !arm_q[6] && sense_edge[6]
		&& pin_flag[6] && !acc_pin[6] |=> pin_flag[6])
		else $error("Edge flag cleared without prior read of one.");
	AST_IRQ: assert property (|(evt_sts_q & evt_en_q) |=> irq_o)
		else $error("Enabled event did not raise the interrupt.");
	AST_NMI_FALL: assert property (!nmi_rise && $fell(nmi_pin_i) |=> nmi_pend_q)
		else $error("Falling NMI edge not latched.");
	// The core must never see the source it just took presented again at once.
	AST_REQ_GAP: assert property (acc_any |=> !req_o)
		else $error("Request still presented right after an accept.");

	CVR_NMI_ACC: cover property (acc_nmi);
	CVR_PIN_ACC: cover property (acc_any && !req_nmi_o);
	CVR_SW_CLR:  cover property (|sw_clr);
	CVR_IRQ:     cover property ($rose(irq_o));
	CVR_NMI_FALL: cover property (!nmi_rise && nmi_hit);

endmodule // eip_top

// >>> hw/eip_defines.svh
`ifndef EIP_DEFINES_SVH
`define EIP_DEFINES_SVH

// Register byte offsets on the Wishbone slave.
`define EIP_OFS_CTL_ONE   8'h00
`define EIP_OFS_CTL_TWO   8'h04
`define EIP_OFS_PRIO_A    8'h08
`define EIP_OFS_PRIO_B    8'h0c
`define EIP_OFS_REQ_STS   8'h10
`define EIP_OFS_EVT_STS   8'h14
`define EIP_OFS_EVT_EN    8'h18
`define EIP_OFS_EVT_CLR   8'h1c

// Field positions.
`define EIP_NMI_POL_BIT   8
`define EIP_NMI_PEND_BIT  8
`define EIP_EVT_NMI_BIT   8
`define EIP_EVT_ACC_BIT   9
`define EIP_EVT_W         10

// Encodings and fixed levels.
`define EIP_EDGE_FALL     2'b01
`define EIP_EDGE_RISE     2'b10
`define EIP_NMI_LEVEL     5'h10
`define EIP_NMI_MASK      4'hf
`define EIP_PRIO_OFF      4'h0

// Reset values.
`define EIP_RST_CTL_ONE   9'h000
`define EIP_RST_CTL_TWO   16'h0000
`define EIP_RST_PRIO      16'h0000
`define EIP_RST_EVT       10'h000
`define EIP_PIN_IDLE      1'b1

`endif

// >>> hw/eip_pkg.sv
package eip_pkg;

	typedef logic [4:0] eip_level_t;

	typedef enum {
		EIP_SRC_NONE,
		EIP_SRC_NMI,
		EIP_SRC_PIN
	} eip_src_e;

endpackage

// >>> hw/eip_pin_detect.sv
`timescale 1ns/1ps
`include "eip_defines.svh"

module eip_pin_detect (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       pin_i,
	input  wire logic       sense_i,
	input  wire logic [1:0] edge_sel_i,
	input  wire logic       clr_i,
	input  wire logic       acc_i,
	output logic            flag_o,
	output logic            evt_o
);
	import eip_pkg::*;

	logic prev_q;
	logic latch_q;

	wire fell    = prev_q & ~pin_i;
	wire rose    = ~prev_q & pin_i;
	// Any edge code other than rising selects falling, so no code leaves a pin dead.
	wire hit     = sense_i & ((edge_sel_i == `EIP_EDGE_RISE) ? rose : fell);
	// A new edge wins over a clear arriving in the same cycle.
	wire latch_d = hit | (sense_i & latch_q & ~clr_i & ~acc_i);

	assign evt_o  = hit;
	assign flag_o = sense_i ? latch_q : ~pin_i;

	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			prev_q  <= `EIP_PIN_IDLE;
			latch_q <= 1'b0;
		end
		else
		begin
			prev_q  <= pin_i;
			latch_q <= latch_d;
		end
	end

	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	AST_FALL: assert property (sense_i && edge_sel_i != `EIP_EDGE_RISE && $fell(pin_i)
		|=> flag_o)
		else $error("Falling edge did not latch a request.");
	AST_RISE: assert property (sense_i && edge_sel_i == `EIP_EDGE_RISE && $rose(pin_i)
		|=> flag_o)
		else $error("Rising edge did not latch a request.");
	AST_EDGE_HOLD: assert property (sense_i && flag_o && !clr_i && !acc_i ##1 sense_i
		|-> flag_o)
		else $error("Latched edge request was lost without accept or clear.");

endmodule // eip_pin_detect

// >>> verif/eip_core_model.sv
`timescale 1ns/1ps

module eip_core_model (
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	input  wire logic       en_i,
	input  wire logic [3:0] delay_i,
	input  wire logic       req_i,
	input  wire logic       mask_load_i,
	input  wire logic [3:0] mask_value_i,
	output logic            accept_o,
	output logic      [3:0] mask_level_o
);
	logic [3:0] wait_q;

	// A busy core stalls for delay_i cycles before it takes a request.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wait_q <= 4'h0;
			accept_o <= 1'b0;
			mask_level_o <= 4'h0;
		end
		else
		begin
			wait_q <= (req_i && !accept_o) ? wait_q + 4'h1 : 4'h0;
			accept_o <= en_i && req_i && !accept_o && wait_q >= delay_i;
			if (mask_load_i)
				mask_level_o <= mask_value_i;
		end
	end
endmodule // eip_core_model

// >>> verif/testbench.sv
`timescale 1ns/1ps
`include "eip_defines.svh"

module testbench;
	import eip_pkg::*;
	logic        clk_i;
	logic        rst_i;
	logic        cyc;
	logic        stb;
	logic        we;
	logic [7:0]  adr;
	logic [31:0] wdat;
	logic [3:0]  sel;
	logic [31:0] rdat;
	logic        ack;
	logic        nmi;
	logic [7:0]  pins;
	logic [3:0]  mask;
	logic        acc;
	logic        req;
	eip_level_t  lvl;
	logic        rnmi;
	logic [2:0]  rpin;
	logic        mload;
	logic [3:0]  mval;
	logic        irq;
	logic        en;
	logic [3:0]  dly;
	logic [31:0] q;
	int          err_count;
	int          n_checks;

	eip_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_ack_o(ack), .nmi_pin_i(nmi), .ext_request_pin_i(pins),
		.cpu_mask_level_i(mask), .cpu_accept_i(acc), .req_o(req), .req_level_o(lvl),
		.req_nmi_o(rnmi), .req_pin_o(rpin), .mask_load_o(mload),
		.mask_value_o(mval), .irq_o(irq));

	eip_core_model i_core (.clk_i(clk_i), .rst_i(rst_i), .en_i(en), .delay_i(dly),
		.req_i(req), .mask_load_i(mload), .mask_value_i(mval), .accept_o(acc),
		.mask_level_o(mask));

	task automatic conclude;
		$display("checks %0d mismatches %0d", n_checks, err_count);
		if (err_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp)
		begin
			err_count++;
			$display("[ERR] t=%0t got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic hung;
		chk(32'h0, 32'h1);
		conclude;
	endtask

	// Outputs are read at the edge itself, so they show the settled value of the cycle before.
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		sel <= 4'hf;
		wdat <= d;
		do
		begin
			@(posedge clk_i);
			n++;
		end
		while (ack !== 1'b1 && n < 20);
		if (n >= 20)
			hung;
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	// Waits for mask_load when use_load is set, otherwise for the request.
	task automatic wait_hi(input logic use_load);
		int n;
		n = 0;
		while ((use_load ? mload : req) !== 1'b1 && n < 20)
		begin
			@(posedge clk_i);
			n++;
		end
		if (n >= 20)
			hung;
	endtask

	task automatic take(input logic [3:0] exp);
		en <= 1'b1;
		wait_hi(1'b1);
		chk({28'h0, mval}, {28'h0, exp});
		en <= 1'b0;
	endtask

	task automatic t_regs;
		wb(1'b0, `EIP_OFS_CTL_ONE, 32'h0);
		chk(q, 32'h0);
		wb(1'b0, 8'h20, 32'h0);
		chk(q, 32'h0);
		wb(1'b1, `EIP_OFS_CTL_ONE, 32'h0c4);
		wb(1'b1, `EIP_OFS_CTL_TWO, 32'h9010);
		wb(1'b1, `EIP_OFS_PRIO_A, 32'h503);
		wb(1'b1, `EIP_OFS_PRIO_B, 32'he000);
		wb(1'b0, `EIP_OFS_PRIO_B, 32'h0);
		chk(q, 32'he000);
		$display("register test done");
	endtask

	task automatic t_level;
		pins[0] <= 1'b0;
		wait_hi(1'b0);
		chk({27'h0, lvl}, 32'h3);
		wb(1'b0, `EIP_OFS_REQ_STS, 32'h0);
		chk(q & 32'h1, 32'h1);
		pins[0] <= 1'b1;
		repeat (2) @(posedge clk_i);
		chk({31'h0, req}, 32'h0);
		wb(1'b0, `EIP_OFS_REQ_STS, 32'h0);
		chk(q & 32'h1, 32'h0);
		$display("level test done");
	endtask

	task automatic t_edges;
		pins[2] <= 1'b0;
		wait_hi(1'b0);
		chk({27'h0, lvl}, 32'h5);
		chk({29'h0, rpin}, 32'h2);
		pins[2] <= 1'b1;
		repeat (3) @(posedge clk_i);
		chk({31'h0, req}, 32'h1);
		take(4'h5);
		wb(1'b0, `EIP_OFS_REQ_STS, 32'h0);
		chk(q & 32'h4, 32'h0);
		pins[7] <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({31'h0, req}, 32'h0);
		pins[7] <= 1'b1;
		wait_hi(1'b0);
		chk({27'h0, lvl}, 32'he);
		dly <= 4'h3;
		take(4'he);
		$display("edge test done");
	endtask

	task automatic t_nmi;
		wb(1'b1, `EIP_OFS_CTL_ONE, 32'h1c4);
		nmi <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({31'h0, req}, 32'h0);
		nmi <= 1'b1;
		wait_hi(1'b0);
		chk({31'h0, rnmi}, 32'h1);
		chk({27'h0, lvl}, 32'h10);
		take(4'hf);
		wb(1'b1, `EIP_OFS_CTL_ONE, 32'h0c4);
		nmi <= 1'b0;
		wait_hi(1'b0);
		chk({31'h0, rnmi}, 32'h1);
		take(4'hf);
		$display("nmi test done");
	endtask

	task automatic t_clear;
		pins[6] <= 1'b0;
		repeat (4) @(posedge clk_i);
		chk({31'h0, req}, 32'h0);
		chk({31'h0, irq}, 32'h0);
		wb(1'b1, `EIP_OFS_REQ_STS, 32'h0);
		wb(1'b0, `EIP_OFS_REQ_STS, 32'h0);
		chk(q & 32'h40, 32'h40);
		wb(1'b1, `EIP_OFS_REQ_STS, 32'h0);
		wb(1'b0, `EIP_OFS_REQ_STS, 32'h0);
		chk(q & 32'h40, 32'h0);
		wb(1'b1, `EIP_OFS_EVT_EN, 32'h40);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h1);
		wb(1'b1, `EIP_OFS_EVT_CLR, 32'h40);
		@(posedge clk_i);
		chk({31'h0, irq}, 32'h0);
		$display("clear test done");
	endtask

	initial
	begin
		clk_i = 1'b0;
		forever #50 clk_i = ~clk_i;
	end

	initial
	begin
		err_count = 0;
		n_checks = 0;
		rst_i = 1'b1;
		{cyc, stb, we, en} = 4'h0;
		adr = 8'h0;
		wdat = 32'h0;
		sel = 4'h0;
		nmi = 1'b1;
		pins = 8'hff;
		dly = 4'h0;
		repeat (5) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		t_regs;
		t_level;
		t_edges;
		t_nmi;
		t_clear;
		conclude;
	end
endmodule // testbench
